// >>> flash_cmd_defines.svh
// command codes, identity values and timing counts of the serial flash link
// Functional notes
// - sleep entered only via sleep command
// - asleep: only wake and reset accepted
// - select released while idle gives standby
// - sleep needs select high right after bit eight
// - sleep state follows a fixed entry delay
// - sleep rejected while internal cycle runs
// - wake is code then select high, delay
// - wake id: three dummies, id repeats
// - host waits longer delay after wake id
// - wake ignored while write in progress
// - maker id: zero address, maker then device
// - address one swaps device before maker
// - dual variant uses two data lines
// - quad variant uses four data lines
// - full ident: maker, type, capacity bytes
// - full ident not decoded while busy
// - select high stops full ident output
// - host avoids full ident while asleep
// - suspend only while busy and not suspended
// - suspend sets flag, clears busy later
// - program suspend bars writes, erases, programs
// - erase suspend bars writes and erases
// - resume needs suspended flag and idle
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH
`define CMD_SLEEP       8'hB9
`define CMD_WAKE_ID     8'hAB
`define CMD_MAKER_ID    8'h90
`define CMD_MAKER_ID2   8'h92
`define CMD_MAKER_ID4   8'h94
`define CMD_FULL_ID     8'h9F
`define CMD_SUSPEND     8'h75
`define CMD_RESUME      8'h7A
`define CMD_RST_EN      8'h66
`define CMD_RST         8'h99
`define CMD_PP          8'h02
`define CMD_QPP         8'h32
`define CMD_SE          8'h20
`define CMD_BE32        8'h52
`define CMD_BE64        8'hD8
`define CMD_CE1         8'hC7
`define CMD_CE2         8'h60
`define CMD_WRSR1       8'h01
`define CMD_WRSR2       8'h31
`define CMD_WRSR3       8'h11
`define CMD_SEC_ERASE   8'h44
`define CMD_SEC_PROG    8'h42
// arbitrary identity values
`define ID_MAKER        8'h5A
`define ID_TYPE         8'h40
`define ID_CAP          8'h18
`define ID_DEVICE       8'h17
// timing in ns, cycle counts at 8 ns clock
`define CLK_NS          8
`define SLEEP_ENTRY_NS  3000
`define WAKE_NS         3000
`define WAKE_ID_NS      5000
`define RESUME_NS       200
`define SLEEP_ENTRY_CYC ((`SLEEP_ENTRY_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_CYC        ((`WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_ID_CYC     ((`WAKE_ID_NS + `CLK_NS - 1) / `CLK_NS)
`define RESUME_CYC      (`RESUME_NS / `CLK_NS)
`define SUSPEND_CYC     16
`define SCK_HALF        10
`endif

// >>> flash_pkg.sv
// shared types of the serial flash link
package flash_pkg;
  typedef enum logic [1:0] {
    LANES_1,
    LANES_2,
    LANES_4
  } lanes_e;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_PROGRAM,
    OP_ERASE
  } op_e;
endpackage

// >>> flash_if.sv
// serial flash link between host and device
`timescale 1ns/1ps
`default_nettype none
interface flash_if;
  logic       cs_n;   // chip select, active low
  logic       sck;    // serial clock from host
  logic [3:0] h_io_o; // host data out
  logic [3:0] h_io_e; // host drive enables
  logic [3:0] d_io_o; // device data out
  logic [3:0] d_io_e; // device drive enables
  wire  [3:0] io;     // resolved lanes
  genvar g;
  for (g = 0; g < 4; g++) begin : g_res
    assign io[g] = h_io_e[g] ? h_io_o[g] : (d_io_e[g] ? d_io_o[g] : 1'b1);
  end
  modport host (output cs_n, output sck, output h_io_o, output h_io_e,
                input io);
  modport device (input cs_n, input sck, input io, output d_io_o,
                  output d_io_e);
endinterface
`default_nettype wire

// >>> flash_sync.sv
// two-flop synchroniser with edge detect on the synced level
`timescale 1ns/1ps
`default_nettype none
module flash_sync #(
  parameter int W = 6
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_s;
  sync_s st_q, st_d;
  // shift chain, s1 read only by s2
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end
  // registers, sync reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end
  assign q_o    = st_q.s2;
  assign rise_o = st_q.s2 & ~st_q.s3;
  assign fall_o = ~st_q.s2 & st_q.s3;
endmodule
`default_nettype wire

// >>> flash_device.sv
// serial flash device end: sleep, id reads, suspend and resume
`include "flash_cmd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_device (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  flash_if.device   bus,
  input  wire logic start_program_i,   // begin internal page program
  input  wire logic start_erase_i,     // begin internal erase
  input  wire logic cycle_done_i,      // internal cycle finishes
  output logic      write_in_progress_o,
  output logic      suspended_o,
  output logic      asleep_o,
  output logic      ready_o,           // accepts commands
  output logic      refused_o,         // pulse: barred command dropped
  output logic [7:0] cmd_o,            // last received command code
  output logic      cmd_valid_o        // pulse with cmd_o
);
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_OUT, ST_SKIP
  } phase_e;
  typedef struct packed {
    phase_e             ph;
    logic [7:0]         cmd;
    logic [7:0]         sh;     // input shifter
    logic [5:0]         bits;   // input bit count
    logic [4:0]         bytes;  // input byte count
    flash_pkg::lanes_e  lanes;
    logic [23:0]        addr;
    logic [23:0]        obuf;   // output pattern
    logic [4:0]         olen;   // pattern length in bits
    logic [4:0]         opos;   // next bit position
    logic [3:0]         dout;
    logic [3:0]         doe;
    logic               write_in_progress_flag;
    logic               sus;
    flash_pkg::op_e     op;
    logic               asleep;
    logic [12:0]        tmr;    // entry / release / suspend timer
    logic               sleeping_pend;
    logic               rst_en;
    logic               refused;
    logic               cv;
  } dev_s;
  dev_s st_q, st_d;
  logic [5:0] sy, ry, fy;
  flash_sync #(.W(6)) u_sync (
    .clk_i    (clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i      ({bus.io, bus.sck, bus.cs_n}),
    .q_o      (sy),
    .rise_o   (ry),
    .fall_o   (fy)
  );
  logic cs_n, sck_r, sck_f;
  logic [3:0] io;
  assign cs_n  = sy[0];
  assign sck_r = ry[1];
  assign sck_f = fy[1];
  assign io    = sy[5:2];
  // lane width in bits per edge
  function automatic logic [2:0] lw(input flash_pkg::lanes_e l);
    unique case (l)
      flash_pkg::LANES_1: lw = 3'd1;
      flash_pkg::LANES_2: lw = 3'd2;
      flash_pkg::LANES_4: lw = 3'd4;
      default:            lw = 3'd1; // unused lane code
    endcase
  endfunction
  // command barred during suspend
  function automatic logic barred(input logic [7:0] c, input flash_pkg::op_e o);
    logic b;
    b = (c == `CMD_WRSR1) || (c == `CMD_WRSR2) || (c == `CMD_WRSR3) ||
        (c == `CMD_SEC_ERASE) || (c == `CMD_SE) || (c == `CMD_BE32) ||
        (c == `CMD_BE64) || (c == `CMD_CE1) || (c == `CMD_CE2);
    if (o == flash_pkg::OP_PROGRAM) begin
      b = b || (c == `CMD_SEC_PROG) || (c == `CMD_PP) || (c == `CMD_QPP);
    end
    barred = b;
  endfunction
  // next state
  always_comb begin
    logic [7:0] nb;
    logic [2:0] w;
    nb = 8'h00;
    w  = lw(st_q.lanes);
    st_d = st_q;
    st_d.refused = 1'b0;
    st_d.cv = 1'b0;
    // internal cycle timer
    if (st_q.tmr != 13'd0) begin
      st_d.tmr = st_q.tmr - 13'd1;
    end
    if (st_q.sleeping_pend && st_q.tmr == 13'd1) begin
      st_d.asleep = 1'b1;
      st_d.sleeping_pend = 1'b0;
    end
    if (st_q.sus && st_q.write_in_progress_flag && st_q.tmr == 13'd1) begin
      st_d.write_in_progress_flag = 1'b0;
    end
    if (!st_q.sus && st_q.op != flash_pkg::OP_NONE && !st_q.write_in_progress_flag &&
        st_q.tmr == 13'd1) begin
      st_d.write_in_progress_flag = 1'b1;
    end
    if (cycle_done_i && st_q.write_in_progress_flag && !st_q.sus) begin
      st_d.write_in_progress_flag = 1'b0;
      st_d.op  = flash_pkg::OP_NONE;
    end
    if ((start_program_i || start_erase_i) && !st_q.write_in_progress_flag && !st_q.sus &&
        !st_q.asleep) begin
      st_d.write_in_progress_flag = 1'b1;
      st_d.op = start_program_i ? flash_pkg::OP_PROGRAM : flash_pkg::OP_ERASE;
    end
    if (cs_n) begin
      // select released: execute on exact byte boundary
      // skipped frames never execute; plain wake ends with dummies owed
      if (ry[0] && st_q.ph != ST_CMD && st_q.ph != ST_SKIP &&
          st_q.bits == 6'd0 && (st_q.bytes == 5'd0 ||
          (st_q.cmd == `CMD_WAKE_ID && st_q.ph == ST_DUMMY &&
           st_q.bytes == 5'd3))) begin
        st_d.cv  = 1'b1;
        st_d.cmd = st_q.cmd;
        if (st_q.cmd == `CMD_SLEEP && !st_q.asleep) begin
          if (!st_q.write_in_progress_flag) begin
            st_d.sleeping_pend = 1'b1;
            st_d.tmr = 13'(`SLEEP_ENTRY_CYC);
          end
        end else if (st_q.cmd == `CMD_WAKE_ID && !st_q.write_in_progress_flag) begin
          st_d.asleep = 1'b0;
          st_d.sleeping_pend = 1'b0;
          // id read out means the longer release delay
          st_d.tmr = (st_q.ph == ST_OUT) ? 13'(`WAKE_ID_CYC) :
                                           13'(`WAKE_CYC);
        end else if (st_q.cmd == `CMD_RST_EN) begin
          st_d.rst_en = 1'b1;
        end else if (st_q.cmd == `CMD_RST && st_q.rst_en) begin
          st_d.asleep = 1'b0;
          st_d.sus = 1'b0;
          st_d.write_in_progress_flag = 1'b0;
          st_d.op  = flash_pkg::OP_NONE;
        end else if (st_q.cmd == `CMD_SUSPEND && !st_q.sus && st_q.write_in_progress_flag &&
                     st_q.op != flash_pkg::OP_NONE && !st_q.asleep) begin
          st_d.sus = 1'b1;
          st_d.tmr = 13'(`SUSPEND_CYC);
        end else if (st_q.cmd == `CMD_RESUME && st_q.sus && !st_q.write_in_progress_flag &&
                     !st_q.asleep) begin
          st_d.sus = 1'b0;
          st_d.tmr = 13'(`RESUME_CYC);
        end else if (st_q.sus && barred(st_q.cmd, st_q.op)) begin
          st_d.refused = 1'b1;
          st_d.cv = 1'b0;
        end
        if (st_q.cmd != `CMD_RST_EN) begin
          st_d.rst_en = 1'b0;
        end
      end else if (ry[0] && st_q.ph == ST_OUT && st_q.cmd == `CMD_WAKE_ID) begin
        st_d.asleep = 1'b0; // wake with id read
        st_d.tmr = 13'(`WAKE_ID_CYC);
      end
      st_d.ph = ST_CMD;
      st_d.bits = 6'd0;
      st_d.bytes = 5'd0;
      st_d.lanes = flash_pkg::LANES_1;
      st_d.doe = 4'h0;
    end else if (st_q.tmr != 13'd0 && !st_q.sus && !st_q.write_in_progress_flag &&
                 st_q.op == flash_pkg::OP_NONE) begin
      st_d.ph = ST_SKIP; // release delay: not ready
    end else if (sck_r && st_q.ph != ST_OUT && st_q.ph != ST_SKIP) begin
      // shift in on rising edge
      unique case (st_q.lanes)
        flash_pkg::LANES_1: nb = {st_q.sh[6:0], io[0]};
        flash_pkg::LANES_2: nb = {st_q.sh[5:0], io[1:0]};
        flash_pkg::LANES_4: nb = {st_q.sh[3:0], io};
      endcase
      st_d.sh = nb;
      st_d.bits = st_q.bits + 6'(w);
      if (st_q.bits + 6'(w) == 6'd8) begin
        st_d.bits = 6'd0;
        if (st_q.ph == ST_CMD) begin
          st_d.cmd = nb;
          st_d.bytes = 5'd0;
          if (st_q.asleep && nb != `CMD_WAKE_ID && nb != `CMD_RST_EN &&
              nb != `CMD_RST) begin
            st_d.ph = ST_SKIP;
          end else if (nb == `CMD_FULL_ID) begin
            if (st_q.write_in_progress_flag) begin
              st_d.ph = ST_SKIP;
            end else begin
              st_d.ph = ST_OUT;
              st_d.obuf = {`ID_MAKER, `ID_TYPE, `ID_CAP};
              st_d.olen = 5'd24;
              st_d.opos = 5'd23;
            end
          end else if (nb == `CMD_WAKE_ID) begin
            st_d.ph = st_q.write_in_progress_flag ? ST_SKIP : ST_DUMMY;
            st_d.bytes = 5'd3;
          end else if (nb == `CMD_MAKER_ID || nb == `CMD_MAKER_ID2 ||
                       nb == `CMD_MAKER_ID4) begin
            st_d.ph = ST_ADDR;
            st_d.bytes = (nb == `CMD_MAKER_ID) ? 5'd3 : 5'd4;
            st_d.lanes = (nb == `CMD_MAKER_ID2) ? flash_pkg::LANES_2 :
                         (nb == `CMD_MAKER_ID4) ? flash_pkg::LANES_4 :
                         flash_pkg::LANES_1;
          end else begin
            st_d.ph = ST_DUMMY; // other commands: swallow trailing bytes
            st_d.bytes = 5'd0;
          end
        end else begin
          if (st_q.ph == ST_ADDR && st_q.bytes > 5'd1) begin
            st_d.addr = {st_q.addr[15:0], nb};
          end
          if (st_q.bytes != 5'd0) begin
            st_d.bytes = st_q.bytes - 5'd1;
          end
          if (st_q.bytes == 5'd1) begin
            st_d.ph = ST_OUT;
            st_d.opos = 5'd15;
            st_d.olen = 5'd16;
            if (st_q.cmd == `CMD_WAKE_ID) begin
              st_d.obuf = {`ID_DEVICE, `ID_DEVICE, 8'h00};
            end else if (((st_q.ph == ST_ADDR && st_q.cmd == `CMD_MAKER_ID) ?
                          nb[0] : st_d.addr[0])) begin
              st_d.obuf = {`ID_DEVICE, `ID_MAKER, 8'h00};
            end else begin
              st_d.obuf = {`ID_MAKER, `ID_DEVICE, 8'h00};
            end
            st_d.obuf = {st_d.obuf[23:8], 8'h00} >> 8;
          end else if (st_q.bytes == 5'd0) begin
            st_d.bytes = 5'd1; // non-zero marks a partial frame
          end
        end
      end
    end else if (sck_f && st_q.ph == ST_OUT) begin
      // shift out on falling edge, MSB first, pattern repeats
      st_d.doe = (st_q.lanes == flash_pkg::LANES_1) ? 4'h2 :
                 (st_q.lanes == flash_pkg::LANES_2) ? 4'h3 : 4'hF;
      unique case (st_q.lanes)
        flash_pkg::LANES_1: st_d.dout = {2'b00, st_q.obuf[st_q.opos], 1'b0};
        flash_pkg::LANES_2: st_d.dout = {2'b00, st_q.obuf[st_q.opos],
                                         st_q.obuf[st_q.opos - 5'd1]};
        flash_pkg::LANES_4: st_d.dout = {st_q.obuf[st_q.opos],
                                         st_q.obuf[st_q.opos - 5'd1],
                                         st_q.obuf[st_q.opos - 5'd2],
                                         st_q.obuf[st_q.opos - 5'd3]};
      endcase
      st_d.opos = (st_q.opos < 5'(w)) ? st_q.olen - 5'd1 : st_q.opos - 5'(w);
    end
  end
  // state register, sync reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= '{ph: ST_CMD, lanes: flash_pkg::LANES_1, op: flash_pkg::OP_NONE,
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end
  assign bus.d_io_o          = st_q.dout;
  assign bus.d_io_e          = st_q.doe;
  assign write_in_progress_o = st_q.write_in_progress_flag;
  assign suspended_o         = st_q.sus;
  assign asleep_o            = st_q.asleep;
  assign ready_o             = (st_q.tmr == 13'd0) || st_q.sus || st_q.write_in_progress_flag;
  assign refused_o           = st_q.refused;
  assign cmd_o               = st_q.cmd;
  assign cmd_valid_o         = st_q.cv;
endmodule
`default_nettype wire

// >>> flash_host.sv
// host end: sends one command frame, captures returned bytes
`include "flash_cmd_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module flash_host (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  flash_if.host            bus,
  input  wire logic        req_i,     // start a frame
  input  wire logic [7:0]  cmd_i,     // command code
  input  wire logic [31:0] tx_i,      // trailing bytes, MSB first
  input  wire logic [2:0]  tx_n_i,    // number of trailing bytes
  input  wire logic [1:0]  lanes_i,   // 0/1/2 -> 1/2/4 lanes after code
  input  wire logic [2:0]  rx_n_i,    // bytes to read back
  output logic             busy_o,
  output logic             done_o,    // pulse after the post-frame gap
  output logic [23:0]      rx_o       // read bytes
);
  typedef enum logic [1:0] { H_IDLE, H_RUN, H_GAP } hstate_e;
  typedef struct packed {
    hstate_e     s;
    logic [5:0]  div;
    logic        sck;
    logic [47:0] sh;
    logic [6:0]  nbits;
    logic [6:0]  nrx;
    logic [1:0]  ln;
    logic [6:0]  cnt;
    logic [23:0] rx;
    logic        done;
    logic [12:0] gap;
  } host_s;
  host_s st_q, st_d;
  logic [3:0] io_s;
  flash_sync #(.W(4)) u_sync (
    .clk_i    (clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i      (bus.io),
    .q_o      (io_s),
    .rise_o   (),
    .fall_o   ()
  );
  // frame sequencer, clock from divider
  always_comb begin
    logic [6:0] w;
    w = 7'd1;
    st_d = st_q;
    st_d.done = 1'b0;
    if (st_q.cnt >= 7'd8) begin
      w = (st_q.ln == 2'd1) ? 7'd2 : (st_q.ln == 2'd2) ? 7'd4 : 7'd1;
    end
    unique case (st_q.s)
      H_IDLE: begin
        if (req_i) begin
          st_d.s = H_RUN;
          st_d.sh = {cmd_i, tx_i, 8'h00};
          st_d.nbits = 7'd8 + {tx_n_i, 3'b000};
          st_d.nrx = {1'b0, rx_n_i, 3'b000};
          st_d.ln = lanes_i;
          st_d.cnt = 7'd0;
          st_d.div = 6'd0;
          st_d.sck = 1'b0;
          st_d.rx = 24'h0;
        end
      end
      H_RUN: begin
        st_d.div = st_q.div + 6'd1;
        if (st_q.div == 6'(`SCK_HALF - 1)) begin
          st_d.div = 6'd0;
          st_d.sck = ~st_q.sck;
          if (st_q.sck) begin
            // falling: advance bit position
            if (st_q.cnt < st_q.nbits) begin
              st_d.sh = st_q.sh << w;
            end
            st_d.cnt = st_q.cnt + w;
            // frame ends right after last full byte
            if (st_q.cnt + w >= st_q.nbits + st_q.nrx) begin
              st_d.s = H_GAP;
              st_d.sck = 1'b0;
              st_d.gap = 13'(`WAKE_ID_CYC);
            end
          end else if (st_q.cnt >= st_q.nbits) begin
            // rising: sample device lanes
            unique case (w)
              7'd2: st_d.rx = {st_q.rx[21:0], io_s[1:0]};
              7'd4: st_d.rx = {st_q.rx[19:0], io_s};
              default: st_d.rx = {st_q.rx[22:0], io_s[1]};
            endcase
          end
        end
      end
      H_GAP: begin
        // user decides order; host only keeps select high
        st_d.gap = st_q.gap - 13'd1;
        if (st_q.gap == 13'd1) begin
          st_d.s = H_IDLE;
          st_d.done = 1'b1;
        end
      end
      default: st_d.s = H_IDLE;
    endcase
  end
  // registers, sync reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q <= '{s: H_IDLE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end
  assign bus.cs_n   = (st_q.s != H_RUN);
  assign bus.sck    = st_q.sck;
  assign bus.h_io_o = (st_q.cnt < 7'd8 || st_q.ln == 2'd0) ?
                      {3'b000, st_q.sh[47]} :
                      (st_q.ln == 2'd1) ? {2'b00, st_q.sh[47:46]} :
                      st_q.sh[47:44];
  assign bus.h_io_e = (st_q.s != H_RUN || st_q.cnt >= st_q.nbits) ? 4'h0 :
                      (st_q.cnt < 7'd8 || st_q.ln == 2'd0) ? 4'h1 :
                      (st_q.ln == 2'd1) ? 4'h3 : 4'hF;
  assign busy_o     = (st_q.s != H_IDLE);
  assign done_o     = st_q.done;
  assign rx_o       = st_q.rx;
endmodule
`default_nettype wire

// >>> flash_link_checker.sv
// assertions on the flash link lanes and the device status levels
`timescale 1ns/1ps
`default_nettype none
module flash_link_checker (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       cs_n,
  input wire logic [3:0] h_io_e,
  input wire logic [3:0] d_io_e,
  input wire logic       write_in_progress_o,
  input wire logic       suspended_o,
  input wire logic       asleep_o,
  input wire logic       refused_o,
  input wire logic       cmd_valid_o
);
  // one clock domain, one reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // device lets go of the lanes once deselected
  property p_release; cs_n [*8] |-> d_io_e == 4'h0; endproperty
  a_release: assert property (p_release) else $error("lanes driven idle");
  // never both ends on one lane at turnaround
  property p_no_clash; (h_io_e & d_io_e) == 4'h0; endproperty
  a_no_clash: assert property (p_no_clash) else $error("lane clash");
  // suspend only out of a running cycle
  property p_sus_cause; $rose(suspended_o) |-> $past(write_in_progress_o);
  endproperty
  a_sus_cause: assert property (p_sus_cause) else $error("bad suspend");
  // busy drops within the suspend latency
  property p_sus_wip; $rose(suspended_o) |-> ##[1:18] !write_in_progress_o;
  endproperty
  a_sus_wip: assert property (p_sus_wip) else $error("busy stays");
  // resume only while idle and suspended
  property p_res_cause; $fell(suspended_o) |-> !$past(write_in_progress_o);
  endproperty
  a_res_cause: assert property (p_res_cause) else $error("bad resume");
  // busy comes back within the resume bound
  property p_res_wip; $fell(suspended_o) |-> ##[1:27] write_in_progress_o;
  endproperty
  a_res_wip: assert property (p_res_wip) else $error("no busy");
  // sleep never entered over a running cycle
  property p_sleep_idle; $rose(asleep_o) |-> !write_in_progress_o; endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep busy");
  // sleep comes only after the entry delay
  property p_sleep_delay; $rose(asleep_o) |-> $past(cs_n, 300); endproperty
  a_sleep_delay: assert property (p_sleep_delay) else $error("early");
  // a refusal happens only while suspended
  property p_ref_sus; refused_o |-> suspended_o; endproperty
  a_ref_sus: assert property (p_ref_sus) else $error("refused idle");
  // a refusal leaves the flags alone
  property p_ref_keep;
    refused_o |=> $stable(suspended_o) && !write_in_progress_o;
  endproperty
  a_ref_keep: assert property (p_ref_keep) else $error("flags moved");
  // execution only after select has gone high
  property p_cmd_sel; cmd_valid_o |-> cs_n && $past(cs_n, 2); endproperty
  a_cmd_sel: assert property (p_cmd_sel) else $error("exec in frame");
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [31:0] tx;
    logic [2:0]  tx_n;
    logic [1:0]  lanes;
    logic [2:0]  rx_n;
    logic [23:0] exp;
  } row_s;
  logic        clk_i     = 1'b0; // system clock
  logic        sys_rst_i = 1'b1; // synchronous reset
  logic        req = 1'b0;       // host frame request
  logic [7:0]  cmd = 8'h00;      // command code
  logic [31:0] tx = 32'h0;       // trailing bytes
  logic [2:0]  tx_n = 3'h0;      // trailing byte count
  logic [1:0]  lanes = 2'h0;     // lane mode
  logic [2:0]  rx_n = 3'h0;      // bytes read back
  logic [2:0]  ctl = 3'h0;       // program, erase, done
  logic        busy, done, write_in_progress_flag, sus, slp, rdy, refd, vld;
  logic [7:0]  cmd_out;          // last received command code
  logic [23:0] rx;               // returned bytes
  int          num_errors = 0;
  int          n_checks = 0;
  int          n_ref = 0;        // refusal pulses seen
  int          cyc = 0;          // timeout counter
  logic [23:0] r0;               // scratch
  // ordinary id reads
  row_s rows [8] = '{
    '{8'h9F, 32'h0, 3'h0, 2'h0, 3'h3, 24'h5A4018},
    '{8'h90, 32'h0, 3'h3, 2'h0, 3'h2, 24'h005A17},
    '{8'h90, 32'h101, 3'h3, 2'h0, 3'h2, 24'h00175A},
    '{8'h92, 32'h0, 3'h4, 2'h1, 3'h3, 24'h5A175A},
    '{8'h92, 32'h100, 3'h4, 2'h1, 3'h3, 24'h175A17},
    '{8'h94, 32'h0, 3'h4, 2'h2, 3'h3, 24'h5A175A},
    '{8'h94, 32'h100, 3'h4, 2'h2, 3'h3, 24'h175A17},
    '{8'hAB, 32'h0, 3'h3, 2'h0, 3'h3, 24'h171717}};
  // codes barred in suspend; last three only in program suspend
  logic [7:0] bar [12] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h20, 8'h52,
    8'hD8, 8'hC7, 8'h60, 8'h42, 8'h02, 8'h32};
  flash_if bus_if ();
  flash_host i_flash_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .bus(bus_if), .req_i(req), .cmd_i(cmd), .tx_i(tx), .tx_n_i(tx_n),
    .lanes_i(lanes), .rx_n_i(rx_n), .busy_o(busy), .done_o(done),
    .rx_o(rx));
  flash_device i_flash_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .bus(bus_if), .start_program_i(ctl[2]), .start_erase_i(ctl[1]),
    .cycle_done_i(ctl[0]), .write_in_progress_o(write_in_progress_flag), .suspended_o(sus),
    .asleep_o(slp), .ready_o(rdy), .refused_o(refd), .cmd_o(cmd_out),
    .cmd_valid_o(vld));
  flash_link_checker u_checker (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cs_n(bus_if.cs_n), .h_io_e(bus_if.h_io_e), .d_io_e(bus_if.d_io_e),
    .write_in_progress_o(write_in_progress_flag), .suspended_o(sus), .asleep_o(slp),
    .refused_o(refd), .cmd_valid_o(vld));
  // clock
  always #4 clk_i = ~clk_i;
  // refusal counter and hang guard
  always @(posedge clk_i) begin
    if (refd === 1'b1) n_ref <= n_ref + 1;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors = num_errors + 1;
      report_and_stop();
    end
  end
  // counts, verdict, end of run
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one compare
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // status levels: asleep, suspended, busy
  task automatic flags(input logic [2:0] e);
    chk({21'h0, slp, sus, write_in_progress_flag}, {21'h0, e});
  endtask
  // one whole frame, waits for done
  task automatic xfer(input logic [7:0] c, input logic [31:0] t,
                      input logic [2:0] tn, input logic [1:0] ln,
                      input logic [2:0] rn);
    int k;
    @(posedge clk_i);
    req <= 1'b1;
    cmd <= c;
    tx <= t;
    tx_n <= tn;
    lanes <= ln;
    rx_n <= rn;
    @(posedge clk_i);
    req <= 1'b0;
    k = 0;
    #1;
    while (done !== 1'b1 && k < 4000) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk({23'h0, k < 4000}, 24'h1);
  endtask
  // one-cycle pulse on the internal cycle controls
  task automatic kick(input logic [2:0] m);
    @(posedge clk_i);
    ctl <= m;
    @(posedge clk_i);
    ctl <= 3'h0;
    repeat (8) @(posedge clk_i);
    #1;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    flags(3'h0);
    foreach (rows[i]) begin
      xfer(rows[i].cmd, rows[i].tx, rows[i].tx_n, rows[i].lanes,
           rows[i].rx_n);
      r0 = 24'hFFFFFF >> (8 * (3 - rows[i].rx_n));
      chk(rx & r0, rows[i].exp);
      chk({16'h0, cmd_out}, {16'h0, rows[i].cmd});
    end
    // sleep, ignored read, plain wake
    xfer(8'hB9, 32'h0, 3'h0, 2'h0, 3'h0);
    flags(3'h4);
    xfer(8'h90, 32'h0, 3'h3, 2'h0, 3'h2);
    chk(rx & 24'h00FFFF, 24'h00FFFF);
    flags(3'h4);
    xfer(8'hAB, 32'h0, 3'h0, 2'h0, 3'h0);
    flags(3'h0);
    chk({23'h0, rdy}, 24'h1);
    // sleep then wake with id
    xfer(8'hB9, 32'h0, 3'h0, 2'h0, 3'h0);
    xfer(8'hAB, 32'h0, 3'h3, 2'h0, 3'h1);
    chk(rx & 24'hFF, 24'h17);
    flags(3'h0);
    // busy: id reads and sleep are not taken
    kick(3'h4);
    flags(3'h1);
    xfer(8'h9F, 32'h0, 3'h0, 2'h0, 3'h3);
    chk(rx, 24'hFFFFFF);
    xfer(8'hAB, 32'h0, 3'h3, 2'h0, 3'h1);
    chk(rx & 24'hFF, 24'hFF);
    xfer(8'hB9, 32'h0, 3'h0, 2'h0, 3'h0);
    flags(3'h1);
    // suspend twice, second one ignored
    xfer(8'h75, 32'h0, 3'h0, 2'h0, 3'h0);
    flags(3'h2);
    xfer(8'h75, 32'h0, 3'h0, 2'h0, 3'h0);
    flags(3'h2);
    // program suspend: every code barred
    foreach (bar[i]) begin
      r0 = n_ref;
      xfer(bar[i], 32'h0, 3'h0, 2'h0, 3'h0);
      chk(n_ref - r0, 24'h1);
      flags(3'h2);
    end
    xfer(8'h7A, 32'h0, 3'h0, 2'h0, 3'h0);
    flags(3'h1);
    kick(3'h1);
    flags(3'h0);
    // resume and suspend ignored when idle
    xfer(8'h7A, 32'h0, 3'h0, 2'h0, 3'h0);
    flags(3'h0);
    xfer(8'h75, 32'h0, 3'h0, 2'h0, 3'h0);
    flags(3'h0);
    // erase suspend: programs pass through
    kick(3'h2);
    xfer(8'h75, 32'h0, 3'h0, 2'h0, 3'h0);
    flags(3'h2);
    foreach (bar[i]) begin
      r0 = n_ref;
      xfer(bar[i], 32'h0, 3'h0, 2'h0, 3'h0);
      chk(n_ref - r0, {23'h0, i < 9});
    end
    // reset in mid-run clears the levels
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    flags(3'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
